// ==== logic/scs_pkg.sv ====
package scs_pkg;

  // register map
  localparam logic [7:0] REG_STATUS_COMMAND = 8'h00;
  localparam logic [7:0] REG_VENDOR_ID_LOW = 8'h01;
  localparam logic [7:0] REG_VENDOR_ID_HIGH = 8'h02;
  localparam logic [7:0] REG_PRODUCT_ID_LOW = 8'h03;
  localparam logic [7:0] REG_PRODUCT_ID_HIGH = 8'h04;
  localparam logic [7:0] REG_DEVICE_RELEASE_LOW = 8'h05;
  localparam logic [7:0] REG_DEVICE_RELEASE_HIGH = 8'h06;
  localparam logic [7:0] REG_CONFIG_BYTE_ONE = 8'h07;
  localparam logic [7:0] REG_CONFIG_BYTE_TWO = 8'h08;
  localparam logic [7:0] REG_FIXED_PORT_MASK = 8'h09;
  localparam logic [7:0] REG_PORT_OFF_SELF_POWER = 8'h0a;
  localparam logic [7:0] REG_PORT_OFF_BUS_POWER = 8'h0b;
  localparam logic [7:0] REG_MAX_POWER_SELF = 8'h0c;
  localparam logic [7:0] REG_MAX_POWER_BUS = 8'h0d;
  localparam logic [7:0] REG_CONTROLLER_CURRENT_SELF = 8'h0e;
  localparam logic [7:0] REG_CONTROLLER_CURRENT_BUS = 8'h0f;
  localparam logic [7:0] REG_POWER_GOOD_DELAY = 8'h10;
  localparam int NUM_CFG_REGS = 16;

  // status_command fields
  localparam int STAT_ATTACH_BIT = 0;
  localparam int STAT_LOCK_BIT = 1;
  localparam int STAT_SOFT_RESET_BIT = 2;
  localparam logic [7:0] REG_RESET_VALUE = 8'h00;

  // load source strap value selecting serial-port loading
  localparam logic [1:0] LOAD_SEL_SERIAL = 2'h3;

  // general call address, never answered
  localparam logic [6:0] GENERAL_CALL_ADDR = 7'h00;

  // clock-low timeout, counted on the link clock
  localparam int LINK_PERIOD_NS = 30;
  localparam int TIMEOUT_MIN_US = 25000;
  localparam int TIMEOUT_MAX_US = 35000;
  localparam int TIMEOUT_CYC = (TIMEOUT_MIN_US * 1000 + LINK_PERIOD_NS - 1) / LINK_PERIOD_NS;

  // serial engine states
  typedef enum logic [3:0] {
    SCS_IDLE = 4'h0,
    SCS_ADDR = 4'h1,
    SCS_ADDR_ACK = 4'h2,
    SCS_REG = 4'h3,
    SCS_REG_ACK = 4'h4,
    SCS_DATA = 4'h5,
    SCS_DATA_ACK = 4'h6,
    SCS_WAIT_STOP_WR = 4'h7,
    SCS_RD_DATA = 4'h8,
    SCS_RD_NACK = 4'h9,
    SCS_WAIT_STOP = 4'ha
  } scs_state_t;

endpackage

// ==== logic/scs_sync.sv ====
`timescale 1ns/100ps
// two-stage synchroniser; first stage feeds only the second
module scs_sync #(
  parameter int W = 1
) (
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic [W-1:0] i_d,
  output logic [W-1:0] o_q
);

  logic [W-1:0] meta_q;

  // two flops in series
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      meta_q <= '0;
      o_q <= '0;
    end else begin
      meta_q <= i_d;
      o_q <= meta_q;
    end
  end

endmodule

// ==== logic/scs_smbus_slave.sv ====
`timescale 1ns/100ps
module scs_smbus_slave #(
  parameter int TIMEOUT_CYC = scs_pkg::TIMEOUT_CYC
) (
  input wire logic i_mclk,
  input wire logic i_nrst,
  input wire logic i_ce,
  input wire logic i_link_clk,
  input wire logic i_load_source_sel_hi,
  input wire logic i_load_source_sel_lo,
  input wire logic [6:0] i_slave_addr,
  input wire logic i_scl,
  input wire logic i_sda,
  output logic o_sda_out,
  output logic o_sda_oe,
  output logic o_eeprom_load_en,
  output logic o_usb_attach,
  output logic o_config_lock,
  output logic [127:0] o_config_bytes
);

  localparam logic [19:0] TO_LAST = 20'(TIMEOUT_CYC - 1);

  // ---------------- core clock domain ----------------
  logic [3:0] m_sync;
  logic smbus_mode_q;
  logic eeprom_en_q;
  logic run_q;
  logic wr_seen_q;
  logic rd_seen_q;
  logic ack_tgl_q;
  logic [7:0] rd_resp_q;
  logic attach_q;
  logic lock_q;
  localparam int NUM_REGS_HI = scs_pkg::NUM_CFG_REGS;
  logic [7:0] mem_q [NUM_REGS_HI:1];
  logic wr_evt;
  logic rd_evt;
  logic [7:0] rd_val;

  // ---------------- link clock domain ----------------
  logic [11:0] l_sync;
  logic ce_l;
  logic run_l;
  logic ack_l;
  logic scl_s;
  logic sda_s;
  logic [6:0] own_addr_l;
  logic scl_p_q;
  logic sda_p_q;
  scs_pkg::scs_state_t st_q;
  logic [2:0] cnt_q;
  logic [7:0] sh_q;
  logic [7:0] rd_sh_q;
  logic got_reg_q;
  logic is_read_q;
  logic oe_q;
  logic [7:0] reg_addr_q;
  logic [7:0] wr_addr_q;
  logic [7:0] wr_data_q;
  logic wr_tgl_q;
  logic rd_tgl_q;
  logic ack_seen_q;
  logic [7:0] rd_data_l_q;
  logic [19:0] lo_cnt_q;
  logic start_ev;
  logic stop_ev;
  logic rise;
  logic fall;
  logic timeout;
  logic addr_ok;

  // straps and link toggles into the core domain
  scs_sync #(.W(4)) u_msync (
    .i_clk(i_mclk),
    .i_nrst(i_nrst),
    .i_d({i_load_source_sel_hi, i_load_source_sel_lo, wr_tgl_q, rd_tgl_q}),
    .o_q(m_sync)
  );

  assign wr_evt = i_ce && (m_sync[1] != wr_seen_q);
  assign rd_evt = i_ce && (m_sync[0] != rd_seen_q);

  // load source decode and engine enable
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      smbus_mode_q <= 1'b0;
      eeprom_en_q <= 1'b0;
      run_q <= 1'b0;
    end else if (i_ce) begin
      smbus_mode_q <= (m_sync[3:2] == scs_pkg::LOAD_SEL_SERIAL);
      eeprom_en_q <= (m_sync[3:2] != scs_pkg::LOAD_SEL_SERIAL);
      run_q <= (m_sync[3:2] == scs_pkg::LOAD_SEL_SERIAL) && !attach_q;
    end
  end

  // status bits: write once, cleared only by the reset pin
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      attach_q <= 1'b0;
      lock_q <= 1'b0;
    end else if (wr_evt && wr_addr_q == scs_pkg::REG_STATUS_COMMAND) begin
      attach_q <= attach_q | wr_data_q[scs_pkg::STAT_ATTACH_BIT];
      lock_q <= lock_q | wr_data_q[scs_pkg::STAT_LOCK_BIT];
    end
  end

  // configuration memory with lock and soft reset
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      for (int i = 1; i <= NUM_REGS_HI; i++) begin
        mem_q[i] <= scs_pkg::REG_RESET_VALUE;
      end
    end else if (wr_evt) begin
      if (wr_addr_q == scs_pkg::REG_STATUS_COMMAND) begin
        if (wr_data_q[scs_pkg::STAT_SOFT_RESET_BIT]) begin
          for (int i = 1; i <= NUM_REGS_HI; i++) begin
            mem_q[i] <= scs_pkg::REG_RESET_VALUE;
          end
        end
      end else if (wr_addr_q <= scs_pkg::REG_POWER_GOOD_DELAY && !lock_q) begin
        mem_q[wr_addr_q[4:0]] <= wr_data_q;
      end
    end
  end

  // read value; soft reset bit always reads zero
  always_comb begin
    rd_val = 8'h00;
    if (wr_addr_q == 8'h00 && reg_addr_q == scs_pkg::REG_STATUS_COMMAND) begin
      rd_val = 8'h00;
    end
    if (reg_addr_q == scs_pkg::REG_STATUS_COMMAND) begin
      rd_val[scs_pkg::STAT_ATTACH_BIT] = attach_q;
      rd_val[scs_pkg::STAT_LOCK_BIT] = lock_q;
    end else if (reg_addr_q <= scs_pkg::REG_POWER_GOOD_DELAY) begin
      rd_val = mem_q[reg_addr_q[4:0]];
    end
  end

  // toggle handshake bookkeeping and read answer
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      wr_seen_q <= 1'b0;
      rd_seen_q <= 1'b0;
      ack_tgl_q <= 1'b0;
      rd_resp_q <= 8'h00;
    end else if (i_ce) begin
      wr_seen_q <= m_sync[1];
      rd_seen_q <= m_sync[0];
      if (rd_evt) begin
        rd_resp_q <= rd_val;
        ack_tgl_q <= ~ack_tgl_q;
      end
    end
  end

  // outputs from the core domain
  assign o_eeprom_load_en = eeprom_en_q;
  assign o_usb_attach = attach_q;
  assign o_config_lock = lock_q;
  for (genvar g = 1; g <= NUM_REGS_HI; g++) begin : g_cfg
    assign o_config_bytes[g*8-1 -: 8] = mem_q[g];
  end

  // no alert pin exists on this block
  // the clock line is never driven, only data is pulled low
  assign o_sda_out = 1'b0;
  assign o_sda_oe = oe_q;

  // pins, straps and core levels into the link domain
  scs_sync #(.W(12)) u_lsync (
    .i_clk(i_link_clk),
    .i_nrst(i_nrst),
    .i_d({i_slave_addr, i_scl, i_sda, ack_tgl_q, run_q, i_ce}),
    .o_q(l_sync)
  );

  assign own_addr_l = l_sync[11:5];
  assign scl_s = l_sync[4];
  assign sda_s = l_sync[3];
  assign ack_l = l_sync[2];
  assign run_l = l_sync[1];
  assign ce_l = l_sync[0];

  // bus condition detection, clock edges tolerate stretching until the clock-low timeout ends the transfer
  assign start_ev = scl_s && scl_p_q && sda_p_q && !sda_s;
  assign stop_ev = scl_s && scl_p_q && !sda_p_q && sda_s;
  assign rise = scl_s && !scl_p_q;
  assign fall = !scl_s && scl_p_q;
  assign timeout = (lo_cnt_q == TO_LAST);
  assign addr_ok = (sh_q[6:0] == own_addr_l) && (sh_q[6:0] != scs_pkg::GENERAL_CALL_ADDR);

  // previous line levels
  always_ff @(posedge i_link_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      scl_p_q <= 1'b1;
      sda_p_q <= 1'b1;
    end else if (ce_l) begin
      scl_p_q <= scl_s;
      sda_p_q <= sda_s;
    end
  end

  // clock-low timeout counter
  always_ff @(posedge i_link_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      lo_cnt_q <= 20'h00000;
    end else if (ce_l) begin
      if (scl_s || st_q == scs_pkg::SCS_IDLE || timeout) begin
        lo_cnt_q <= 20'h00000;
      end else begin
        lo_cnt_q <= lo_cnt_q + 20'h00001;
      end
    end
  end

  // read answer capture from the core domain
  always_ff @(posedge i_link_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      ack_seen_q <= 1'b0;
      rd_data_l_q <= 8'h00;
    end else if (ce_l) begin
      ack_seen_q <= ack_l;
      if (ack_l != ack_seen_q) begin
        rd_data_l_q <= rd_resp_q;
      end
    end
  end

  // serial protocol engine
  always_ff @(posedge i_link_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      st_q <= scs_pkg::SCS_IDLE;
      cnt_q <= 3'h0;
      sh_q <= 8'h00;
      rd_sh_q <= 8'h00;
      got_reg_q <= 1'b0;
      is_read_q <= 1'b0;
      oe_q <= 1'b0;
      reg_addr_q <= 8'h00;
      wr_addr_q <= 8'h00;
      wr_data_q <= 8'h00;
      wr_tgl_q <= 1'b0;
      rd_tgl_q <= 1'b0;
    end else if (ce_l) begin
      if (!run_l || timeout) begin
        st_q <= scs_pkg::SCS_IDLE;
        oe_q <= 1'b0;
      end else if (stop_ev) begin
        if (st_q == scs_pkg::SCS_WAIT_STOP_WR) begin
          wr_tgl_q <= ~wr_tgl_q;
        end
        st_q <= scs_pkg::SCS_IDLE;
        oe_q <= 1'b0;
      end else if (start_ev) begin
        // a restart shows one clock rise in the data slot before its falling data edge
        got_reg_q <= (st_q == scs_pkg::SCS_DATA) && (cnt_q == 3'h1);
        st_q <= scs_pkg::SCS_ADDR;
        cnt_q <= 3'h0;
        oe_q <= 1'b0;
      end else begin
        case (st_q)
          scs_pkg::SCS_ADDR: begin
            if (rise) begin
              sh_q <= {sh_q[6:0], sda_s};
              cnt_q <= cnt_q + 3'h1;
              if (cnt_q == 3'h7) begin
                is_read_q <= sda_s;
                if (addr_ok && (sda_s == got_reg_q)) begin
                  st_q <= scs_pkg::SCS_ADDR_ACK;
                end else begin
                  st_q <= scs_pkg::SCS_IDLE;
                end
              end
            end
          end
          scs_pkg::SCS_ADDR_ACK: begin
            if (fall) begin
              if (!oe_q) begin
                oe_q <= 1'b1;
              end else if (is_read_q) begin
                st_q <= scs_pkg::SCS_RD_DATA;
                oe_q <= !rd_data_l_q[7];
                rd_sh_q <= {rd_data_l_q[6:0], 1'b0};
                cnt_q <= 3'h0;
              end else begin
                st_q <= scs_pkg::SCS_REG;
                oe_q <= 1'b0;
                cnt_q <= 3'h0;
              end
            end
          end
          scs_pkg::SCS_REG: begin
            if (rise) begin
              sh_q <= {sh_q[6:0], sda_s};
              cnt_q <= cnt_q + 3'h1;
              if (cnt_q == 3'h7) begin
                reg_addr_q <= {sh_q[6:0], sda_s};
                rd_tgl_q <= ~rd_tgl_q;
                st_q <= scs_pkg::SCS_REG_ACK;
              end
            end
          end
          scs_pkg::SCS_REG_ACK: begin
            if (fall) begin
              if (!oe_q) begin
                oe_q <= 1'b1;
              end else begin
                st_q <= scs_pkg::SCS_DATA;
                oe_q <= 1'b0;
                cnt_q <= 3'h0;
              end
            end
          end
          scs_pkg::SCS_DATA: begin
            if (rise) begin
              sh_q <= {sh_q[6:0], sda_s};
              cnt_q <= cnt_q + 3'h1;
              if (cnt_q == 3'h7) begin
                wr_addr_q <= reg_addr_q;
                wr_data_q <= {sh_q[6:0], sda_s};
                st_q <= scs_pkg::SCS_DATA_ACK;
              end
            end
          end
          scs_pkg::SCS_DATA_ACK: begin
            if (fall) begin
              if (!oe_q) begin
                oe_q <= 1'b1;
              end else begin
                st_q <= scs_pkg::SCS_WAIT_STOP_WR;
                oe_q <= 1'b0;
              end
            end
          end
          scs_pkg::SCS_WAIT_STOP_WR: begin
            // a stop needs one clock rise; a fall after it starts an extra byte
            if (fall) begin
              st_q <= scs_pkg::SCS_IDLE;
            end
          end
          scs_pkg::SCS_RD_DATA: begin
            if (rise) begin
              cnt_q <= cnt_q + 3'h1;
              if (cnt_q == 3'h7) begin
                st_q <= scs_pkg::SCS_RD_NACK;
              end
            end else if (fall) begin
              oe_q <= !rd_sh_q[7];
              rd_sh_q <= {rd_sh_q[6:0], 1'b0};
            end
          end
          scs_pkg::SCS_RD_NACK: begin
            if (fall) begin
              oe_q <= 1'b0;
            end else if (rise) begin
              st_q <= scs_pkg::SCS_WAIT_STOP;
            end
          end
          default: begin
            oe_q <= 1'b0;
          end
        endcase
      end
    end
  end

  // ---------------- checks ----------------
  idle_quiet_a: assert property (@(posedge i_link_clk) disable iff (!i_nrst)
    (st_q == scs_pkg::SCS_IDLE) |-> !oe_q) else $error("data driven while idle");

  foreign_addr_a: assert property (@(posedge i_link_clk) disable iff (!i_nrst)
    (ce_l && run_l && !timeout && !start_ev && !stop_ev && st_q == scs_pkg::SCS_ADDR && rise
     && cnt_q == 3'h7 && !addr_ok) |=> (st_q == scs_pkg::SCS_IDLE) [*2])
    else $error("foreign address not ignored");

  // in the acknowledge slot the address sits above the direction bit
  general_call_a: assert property (@(posedge i_link_clk) disable iff (!i_nrst)
    (st_q == scs_pkg::SCS_ADDR_ACK) |-> (sh_q[7:1] != scs_pkg::GENERAL_CALL_ADDR))
    else $error("general call acknowledged");

  start_stop_a: assert property (@(posedge i_link_clk) disable iff (!i_nrst)
    (ce_l && stop_ev) |=> (st_q == scs_pkg::SCS_IDLE) && !oe_q) else $error("stop did not idle");

  timeout_idle_a: assert property (@(posedge i_link_clk) disable iff (!i_nrst)
    (ce_l && timeout) |=> (st_q == scs_pkg::SCS_IDLE) && (lo_cnt_q == 20'h00000))
    else $error("timeout did not reset");

  single_byte_a: assert property (@(posedge i_link_clk) disable iff (!i_nrst)
    (st_q == scs_pkg::SCS_WAIT_STOP || st_q == scs_pkg::SCS_WAIT_STOP_WR) |-> !oe_q)
    else $error("extra byte driven");

  commit_on_stop_a: assert property (@(posedge i_link_clk) disable iff (!i_nrst)
    $changed(wr_tgl_q) |-> $past(st_q) == scs_pkg::SCS_WAIT_STOP_WR)
    else $error("write without full sequence");

  lock_guard_a: assert property (@(posedge i_mclk) disable iff (!i_nrst)
    (wr_evt && lock_q && wr_addr_q != scs_pkg::REG_STATUS_COMMAND && wr_addr_q <= scs_pkg::REG_POWER_GOOD_DELAY)
    |=> $stable(o_config_bytes)) else $error("locked register changed");

  once_bits_a: assert property (@(posedge i_mclk) disable iff (!i_nrst)
    ($past(lock_q) |-> lock_q) and ($past(attach_q) |-> attach_q))
    else $error("write-once bit cleared");

  soft_reset_a: assert property (@(posedge i_mclk) disable iff (!i_nrst)
    (wr_evt && wr_addr_q == scs_pkg::REG_STATUS_COMMAND && wr_data_q[scs_pkg::STAT_SOFT_RESET_BIT])
    |=> (o_config_bytes == 128'h0) ##1 (rd_val[scs_pkg::STAT_SOFT_RESET_BIT] == 1'b0))
    else $error("soft reset incomplete");

  eeprom_off_a: assert property (@(posedge i_mclk) disable iff (!i_nrst)
    smbus_mode_q |-> !o_eeprom_load_en) else $error("eeprom fetch in serial mode");

  attach_stops_a: assert property (@(posedge i_mclk) disable iff (!i_nrst)
    (i_ce && attach_q) |=> !run_q) else $error("interface alive after attach");

endmodule

// ==== verif/scs_host_model.sv ====
`timescale 1ns/100ps
// bus master standing in for the host processor; a released line reads high
module scs_host_model #(
  parameter int Q = 63
) (
  input wire logic i_mclk,
  input wire logic i_sda,
  output logic o_scl,
  output logic o_sda_low
);
  // idle bus: clock high, data released
  initial begin
    o_scl = 1'b1;
    o_sda_low = 1'b0;
  end

  // quarter bus period; every edge lands on a falling core edge
  task automatic wq(input int n);
    repeat (n * Q) @(negedge i_mclk);
  endtask

  // one bit; data moves a quarter period after scl falls, so it never looks like start or stop
  task automatic bit_x(input logic low, output logic seen);
    wq(1);
    o_sda_low = low;
    wq(1);
    o_scl = 1'b1;
    wq(1);
    seen = i_sda;
    wq(1);
    o_scl = 1'b0;
  endtask

  // start, also used as repeated start from a low clock
  task automatic start_c();
    wq(1);
    o_sda_low = 1'b0;
    wq(1);
    o_scl = 1'b1;
    wq(1);
    o_sda_low = 1'b1;
    wq(1);
    o_scl = 1'b0;
  endtask

  task automatic stop_c();
    wq(1);
    o_sda_low = 1'b1;
    wq(1);
    o_scl = 1'b1;
    wq(1);
    o_sda_low = 1'b0;
    wq(2);
  endtask

  // byte out, eight bits highest first, then the acknowledge slot
  task automatic tx(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--)
      bit_x(!b[i], s);
    bit_x(1'b0, s);
    ack = !s;
  endtask

  task automatic rx(output logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_x(1'b0, s);
      b[i] = s;
    end
    bit_x(1'b0, s); // not-acknowledge closes the read
  endtask

  // write of nb bytes, stops early when a byte is refused
  task automatic wr(input logic [6:0] a, input logic [7:0] ra, input logic [7:0] d, input int nb,
                    output logic [2:0] ak);
    ak = 3'h0;
    start_c();
    tx({a, 1'b0}, ak[0]);
    if (ak[0] && nb > 1)
      tx(ra, ak[1]);
    if (ak[1] && nb > 2)
      tx(d, ak[2]);
    stop_c();
  endtask

  // register address, repeated start, one byte back
  task automatic rd(input logic [6:0] a, input logic [7:0] ra, output logic [7:0] d,
                    output logic [2:0] ak);
    ak = 3'h0;
    d = 8'h00;
    start_c();
    tx({a, 1'b0}, ak[0]);
    if (ak[0])
      tx(ra, ak[1]);
    if (ak[1]) begin
      start_c();
      tx({a, 1'b1}, ak[2]);
      if (ak[2])
        rx(d);
    end
    stop_c();
  endtask

  // address sent, then the clock is held low in the acknowledge slot
  task automatic stall_begin(input logic [6:0] a);
    logic s;
    logic [7:0] b;
    b = {a, 1'b0};
    start_c();
    for (int i = 7; i >= 0; i--)
      bit_x(!b[i], s);
    wq(1);
    o_sda_low = 1'b0;
  endtask

  task automatic stall_end();
    o_scl = 1'b1;
    wq(2);
  endtask
endmodule

// ==== verif/tb_smbus_config_slave.sv ====
`timescale 1ns/100ps
// self-checking bench for the serial configuration slave
module tb_smbus_config_slave;
  localparam int TO_CYC = 200;
  logic mclk = 1'b0;
  logic link_clk = 1'b0;
  logic nrst = 1'b0;
  logic sel_hi = 1'b0;
  logic sel_lo = 1'b0;
  logic [6:0] sa = 7'h08;
  logic scl;
  logic host_low;
  logic sda_out;
  logic sda_oe;
  logic eeprom_en;
  logic attach;
  logic lock;
  logic [127:0] cfg;
  logic [7:0] mirror [1:16];
  int mismatches = 0;
  int total_checks = 0;
  wire sda = !(host_low || (sda_oe && !sda_out)); // pulled-up open-drain wire

  // core clock and an unrelated link clock
  always #4 mclk = ~mclk;
  initial begin
    #7.3;
    forever #15 link_clk = ~link_clk;
  end

  scs_smbus_slave #(.TIMEOUT_CYC(TO_CYC)) i_scs_smbus_slave (
    .i_mclk(mclk), .i_nrst(nrst), .i_ce(1'b1), .i_link_clk(link_clk),
    .i_load_source_sel_hi(sel_hi), .i_load_source_sel_lo(sel_lo), .i_slave_addr(sa),
    .i_scl(scl), .i_sda(sda), .o_sda_out(sda_out), .o_sda_oe(sda_oe),
    .o_eeprom_load_en(eeprom_en), .o_usb_attach(attach), .o_config_lock(lock), .o_config_bytes(cfg));

  scs_host_model i_scs_host_model (.i_mclk(mclk), .i_sda(sda), .o_scl(scl), .o_sda_low(host_low));

  task automatic give_verdict();
    $display("checks=%0d mismatches=%0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic check(input logic [127:0] seen, input logic [127:0] exp);
    total_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // expected configuration image from the mirror
  function automatic logic [127:0] cfg_exp();
    logic [127:0] v;
    for (int n = 1; n <= 16; n++)
      v[n*8-1 -: 8] = mirror[n];
    return v;
  endfunction

  // bounded wait for the data drive to reach a level
  task automatic wait_oe(input logic v, input int n);
    int k;
    k = 0;
    while (sda_oe !== v && k < n) begin
      @(negedge mclk);
      k++;
    end
    check(128'(sda_oe), 128'(v));
  endtask

  // write through the host, then acknowledges and image compared
  task automatic wr_chk(input logic [6:0] a, input logic [7:0] ra, input logic [7:0] d, input int nb,
                        input logic [2:0] ak_exp, input logic upd);
    logic [2:0] ak;
    i_scs_host_model.wr(a, ra, d, nb, ak);
    if (upd)
      mirror[ra[4:0]] = d;
    repeat (20) @(negedge mclk);
    check(128'(ak), 128'(ak_exp));
    check(cfg, cfg_exp());
  endtask

  task automatic rd_chk(input logic [7:0] ra, input logic [7:0] exp);
    logic [2:0] ak;
    logic [7:0] d;
    i_scs_host_model.rd(sa, ra, d, ak);
    check(128'(ak), 128'h7);
    check(128'(d), 128'(exp));
  endtask

  // hang guard
  initial begin
    repeat (100000) @(posedge mclk);
    mismatches++;
    give_verdict();
  end

  // main sequence
  initial begin
    logic [7:0] ra;
    logic [7:0] d;
    void'($urandom(32'h3969));
    for (int n = 1; n <= 16; n++)
      mirror[n] = 8'h00;
    sa = 7'h08 + 7'($urandom % 56);
    repeat (8) @(negedge mclk);
    check(128'({sda_oe, eeprom_en, attach, lock}), 128'h0);
    check(cfg, 128'h0);
    nrst = 1'b1;
    repeat (8) @(negedge mclk);
    check(128'(eeprom_en), 128'h1);
    sel_hi = 1'b1;
    sel_lo = 1'b1;
    repeat (250) @(negedge mclk);
    check(128'(eeprom_en), 128'h0);
    for (int i = 0; i < 2; i++) begin
      ra = (i == 0) ? 8'h01 : 8'h10;
      d = 8'($urandom) | 8'h01;
      wr_chk(sa, ra, d, 3, 3'h7, 1'b1);
    end
    rd_chk(8'h10, mirror[16]);
    d = 8'($urandom);
    wr_chk(sa | 7'h40, 8'h01, d, 3, 3'h0, 1'b0);
    wr_chk(7'h00, 8'h01, d, 3, 3'h0, 1'b0);
    ra = 8'h11 + 8'($urandom % 239);
    wr_chk(sa, ra, d, 3, 3'h7, 1'b0);
    rd_chk(ra, 8'h00);
    wr_chk(sa, 8'h01, ~mirror[1], 2, 3'h3, 1'b0);
    i_scs_host_model.start_c();
    i_scs_host_model.stop_c();
    check(128'(sda_oe), 128'h0);
    i_scs_host_model.stall_begin(sa);
    wait_oe(1'b1, 200);
    repeat (600) @(negedge mclk);
    check(128'(sda_oe), 128'h1);
    wait_oe(1'b0, 1000);
    i_scs_host_model.stall_end();
    for (int n = 1; n <= 16; n++)
      mirror[n] = 8'h00;
    wr_chk(sa, 8'h00, 8'h04, 3, 3'h7, 1'b0);
    check(128'({attach, lock}), 128'h0);
    wr_chk(sa, 8'h00, 8'h02, 3, 3'h7, 1'b0);
    check(128'(lock), 128'h1);
    wr_chk(sa, 8'h05, 8'($urandom) | 8'h01, 3, 3'h7, 1'b0);
    check(128'(attach), 128'h0);
    wr_chk(sa, 8'h00, 8'h01, 3, 3'h7, 1'b0);
    check(128'({attach, lock}), 128'h3);
    wr_chk(sa, 8'h01, 8'h33, 3, 3'h0, 1'b0);
    give_verdict();
  end
endmodule
